// file: shared/sfrbk_pkg.sv
// Summary of operation
// - status bit 3 reads one once the brightness ramp has finished, zero while ramping
// - status bit 2 reads one when the external thermistor is absent
// - status bit 1 reads one when the external cold limit is detected
// - status bit 0 reads one when the external hot limit is detected
// - protection bit 6 flags input supply overvoltage
// - protection bit 5 flags input supply undervoltage lockout
// - protection bit 4 flags thermal shutdown, bit 3 boost overcurrent
// - protection bit 2 flags boost output overvoltage
// - protection bit 1 flags power-line switch overcurrent
// - protection bit 0 flags charge pump output too low
// - string bit 5 open, bit 4 shorted, bits 3:0 one-hot affected string
// - writing one to clear register bit 0 clears latched faults; bit is write-only
// - revision register: full-layer revision bits 7:4, interconnect mask revision bits 3:0
// - die temperature 11 bits: high byte bits 2:0, low byte eight bits
// - reading temperature high byte latches full value for the later low byte read
// - reading sink level high byte latches sink level and duty together
// - status, protection, string fault and clear registers reset to zero
// - duty readback high byte at 0x17, low at 0x18, from latched data
package sfrbk_pkg;
    localparam logic [7:0] ADDR_CONDITION  = 8'h0e;
    localparam logic [7:0] ADDR_PROTECTION = 8'h0f;
    localparam logic [7:0] ADDR_STRING     = 8'h10;
    localparam logic [7:0] ADDR_CLEAR      = 8'h11;
    localparam logic [7:0] ADDR_REVISION   = 8'h12;
    localparam logic [7:0] ADDR_HEAT_HIGH  = 8'h13;
    localparam logic [7:0] ADDR_HEAT_LOW   = 8'h14;
    localparam logic [7:0] ADDR_SINK_HIGH  = 8'h15;
    localparam logic [7:0] ADDR_SINK_LOW   = 8'h16;
    localparam logic [7:0] ADDR_DUTY_HIGH  = 8'h17;
    localparam logic [7:0] ADDR_DUTY_LOW   = 8'h18;
    localparam int         CLEAR_BIT       = 0;
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    // arbitrary revision values
    localparam logic [3:0] FULL_LAYER_REV  = 4'h1;
    localparam logic [3:0] INTERCONNECT_MASK_REV = 4'h0;
endpackage : sfrbk_pkg

// file: design/sfrbk_bank.sv
`timescale 1ns/1ps
module sfrbk_bank
(
    input  wire logic        CLK,            // register clock
    input  wire logic        RESETN,         // sync reset, active low
    input  wire logic        RD_STB,         // one-cycle read strobe
    input  wire logic        WR_STB,         // one-cycle write strobe
    input  wire logic [7:0]  ADDR,           // register address
    input  wire logic [7:0]  WDATA,          // write data
    output logic      [7:0]  RDATA,          // read data, valid cycle after RD_STB
    input  wire logic        RAMP_FINISHED,  // brightness ramp done (async)
    input  wire logic        THERM_ABSENT,   // thermistor absent (async)
    input  wire logic        EXT_COLD,       // external cold limit (async)
    input  wire logic        EXT_HOT,        // external hot limit (async)
    input  wire logic [6:0]  PROT_EVENTS,    // protection events, bit = flag (async)
    input  wire logic        STRING_OPEN,    // open string event (async)
    input  wire logic        STRING_SHORT,   // shorted string event (async)
    input  wire logic [3:0]  STRING_SEL,     // one-hot affected string (async)
    input  wire logic [10:0] DIE_HEAT,       // die temperature sample, same clock
    input  wire logic [11:0] SINK_LEVEL,     // sink level sample, same clock
    input  wire logic [15:0] DUTY            // duty sample, same clock
);
    // three-stage synchronisers for asynchronous condition inputs
    localparam int NSYNC = 17;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff;
    logic [NSYNC-1:0] clean_ff;
    assign async_in = {STRING_SEL, STRING_SHORT, STRING_OPEN, PROT_EVENTS,
                       RAMP_FINISHED, THERM_ABSENT, EXT_COLD, EXT_HOT};

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end
        else
        begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // change accepted once stages two and three agree
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            clean_ff <= '0;
        else
            for (int i = 0; i < NSYNC; i++)
                if (s2_ff[i] == s3_ff[i])
                    clean_ff[i] <= s3_ff[i];
    end

    logic [3:0] cond_live;
    logic [6:0] prot_live;
    logic       open_live, short_live;
    logic [3:0] sel_live;
    assign cond_live  = clean_ff[3:0];
    assign prot_live  = clean_ff[10:4];
    assign open_live  = clean_ff[11];
    assign short_live = clean_ff[12];
    assign sel_live   = clean_ff[16:13];

    logic clear_hit;
    assign clear_hit = WR_STB && (ADDR == sfrbk_pkg::ADDR_CLEAR) && WDATA[sfrbk_pkg::CLEAR_BIT];

    // condition flags follow live state, not latched
    logic [3:0] cond_ff;
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            cond_ff <= sfrbk_pkg::RESET_BYTE[3:0];
        else
            cond_ff <= cond_live;
    end

    // sticky faults; an event in the clear cycle wins
    logic [6:0] prot_ff;
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            prot_ff <= sfrbk_pkg::RESET_BYTE[6:0];
        else
            prot_ff <= (clear_hit ? 7'h00 : prot_ff) | prot_live;
    end

    logic       open_ff, short_ff;
    logic [3:0] sel_ff;
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            open_ff  <= 1'b0;
            short_ff <= 1'b0;
            sel_ff   <= 4'h0;
        end
        else
        begin
            open_ff  <= (open_ff & ~clear_hit) | open_live;
            short_ff <= (short_ff & ~clear_hit) | short_live;
            if (open_live || short_live)
                sel_ff <= sel_live;
            else if (clear_hit)
                sel_ff <= 4'h0;
        end
    end

    // snapshot latched on high-byte read so byte pairs stay coherent
    logic        rd_heat_high, rd_sink_high;
    logic [10:0] heat_snap_ff;
    logic [11:0] sink_snap_ff;
    logic [15:0] duty_snap_ff;
    assign rd_heat_high = RD_STB && (ADDR == sfrbk_pkg::ADDR_HEAT_HIGH);
    assign rd_sink_high = RD_STB && (ADDR == sfrbk_pkg::ADDR_SINK_HIGH);

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            heat_snap_ff <= 11'h000;
        else if (rd_heat_high)
            heat_snap_ff <= DIE_HEAT;
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            sink_snap_ff <= 12'h000;
            duty_snap_ff <= 16'h0000;
        end
        else if (rd_sink_high)
        begin
            sink_snap_ff <= SINK_LEVEL;
            duty_snap_ff <= DUTY;
        end
    end

    // temperature and sink level high bytes answer with the fresh sample they latch; duty high byte reads the snapshot
    logic [7:0] nxt_rdata;
    always_comb
    begin
        nxt_rdata = 8'h00;
        case (ADDR)
            sfrbk_pkg::ADDR_CONDITION:  nxt_rdata = {4'h0, cond_ff};
            sfrbk_pkg::ADDR_PROTECTION: nxt_rdata = {1'b0, prot_ff};
            sfrbk_pkg::ADDR_STRING:     nxt_rdata = {2'b00, open_ff, short_ff, sel_ff};
            sfrbk_pkg::ADDR_REVISION:   nxt_rdata = {sfrbk_pkg::FULL_LAYER_REV,
                                                     sfrbk_pkg::INTERCONNECT_MASK_REV};
            sfrbk_pkg::ADDR_HEAT_HIGH:  nxt_rdata = {5'h00, DIE_HEAT[10:8]};
            sfrbk_pkg::ADDR_HEAT_LOW:   nxt_rdata = heat_snap_ff[7:0];
            sfrbk_pkg::ADDR_SINK_HIGH:  nxt_rdata = {4'h0, SINK_LEVEL[11:8]};
            sfrbk_pkg::ADDR_SINK_LOW:   nxt_rdata = sink_snap_ff[7:0];
            sfrbk_pkg::ADDR_DUTY_HIGH:  nxt_rdata = duty_snap_ff[15:8];
            sfrbk_pkg::ADDR_DUTY_LOW:   nxt_rdata = duty_snap_ff[7:0];
            default:                    nxt_rdata = 8'h00; // clear register is write-only
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            RDATA <= 8'h00;
        else if (RD_STB)
            RDATA <= nxt_rdata;
    end

    // assertions
    AST_CLEAR_DROPS: assert property (@(posedge CLK) disable iff (!RESETN)
        clear_hit && !prot_live[6] |=> !prot_ff[6])
        else $error("clear write did not drop overvoltage flag");
    AST_STICKY: assert property (@(posedge CLK) disable iff (!RESETN)
        prot_ff[5] && !clear_hit |=> prot_ff[5])
        else $error("fault flag fell without clear");
    AST_SET_WINS: assert property (@(posedge CLK) disable iff (!RESETN)
        clear_hit && prot_live[4] |=> prot_ff[4])
        else $error("event lost in clear cycle");
    AST_RAMP_BIT: assert property (@(posedge CLK) disable iff (!RESETN)
        RD_STB && ADDR == sfrbk_pkg::ADDR_CONDITION |=> RDATA[3] == $past(cond_ff[3]))
        else $error("ramp bit readback mismatch");
    AST_COND_RSV: assert property (@(posedge CLK) disable iff (!RESETN)
        $past(RD_STB) && $past(ADDR) == sfrbk_pkg::ADDR_CONDITION |-> RDATA[7:4] == 4'h0)
        else $error("reserved condition bits nonzero");
    AST_HEAT_PAIR: assert property (@(posedge CLK) disable iff (!RESETN)
        rd_heat_high ##1 (RD_STB && ADDR == sfrbk_pkg::ADDR_HEAT_LOW) |=>
        RDATA == $past(DIE_HEAT[7:0], 2))
        else $error("temperature low byte not from latched sample");
    AST_DUTY_LATCH: assert property (@(posedge CLK) disable iff (!RESETN)
        rd_sink_high |=> duty_snap_ff == $past(DUTY))
        else $error("duty not latched with sink level");
    AST_STRING_ONEHOT: assert property (@(posedge CLK) disable iff (!RESETN)
        (open_live || short_live) && $onehot(sel_live) |=> $onehot(sel_ff))
        else $error("string indicator not one-hot");
    AST_REV: assert property (@(posedge CLK) disable iff (!RESETN)
        RD_STB && ADDR == sfrbk_pkg::ADDR_REVISION |=> RDATA[7:4] == sfrbk_pkg::FULL_LAYER_REV)
        else $error("revision field wrong");
    AST_RESET: assert property (@(posedge CLK)
        !RESETN |=> prot_ff == 7'h00 && !open_ff && cond_ff == 4'h0)
        else $error("flags not zero after reset");

    COV_CLEAR: cover property (@(posedge CLK) disable iff (!RESETN) prot_ff != 7'h00 ##1 clear_hit);
    COV_HEAT: cover property (@(posedge CLK) disable iff (!RESETN)
        rd_heat_high ##1 (RD_STB && ADDR == sfrbk_pkg::ADDR_HEAT_LOW));
    COV_SINK: cover property (@(posedge CLK) disable iff (!RESETN)
        rd_sink_high ##[1:4] (RD_STB && ADDR == sfrbk_pkg::ADDR_DUTY_LOW));
    COV_OPEN: cover property (@(posedge CLK) disable iff (!RESETN) $rose(open_ff));
endmodule // sfrbk_bank

// file: testbench/sfrbk_host_model.sv
`timescale 1ns/1ps
module sfrbk_host_model
(
    input  wire logic       clk,    // register clock
    input  wire logic [7:0] rdata,  // read data from bank
    output logic            rd_stb, // read strobe
    output logic            wr_stb, // write strobe
    output logic      [7:0] addr,   // register address
    output logic      [7:0] wdata   // write data
);
    initial
    begin
        rd_stb = 1'b0;
        wr_stb = 1'b0;
        addr   = 8'hff;
        wdata  = 8'h00;
    end

    // host does not enforce high-byte-first order; callers sequence it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        rd_stb = 1'b1;
        addr   = a;
        @(negedge clk);
        rd_stb = 1'b0;
        addr   = ~a; // idle bus never shows the stale address
        d      = rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        wr_stb = 1'b1;
        addr   = a;
        wdata  = v;
        @(negedge clk);
        wr_stb = 1'b0;
        addr   = ~a;
        wdata  = ~v;
    endtask
endmodule // sfrbk_host_model

// file: testbench/status_fault_readback_bank_tb_top.sv
`timescale 1ns/1ps
module status_fault_readback_bank_tb_top;
    logic        clk, resetn, rd_stb, wr_stb, ramp, absent, cold, hot, sopen, sshort;
    logic [7:0]  addr, wdata, rdata;
    logic [6:0]  prot;
    logic [3:0]  ssel;
    logic [10:0] heat;
    logic [11:0] sink;
    logic [15:0] duty;
    int          err_total, n_checks;

    sfrbk_bank i_sfrbk_bank (.CLK(clk), .RESETN(resetn), .RD_STB(rd_stb), .WR_STB(wr_stb), .ADDR(addr),
        .WDATA(wdata), .RDATA(rdata), .RAMP_FINISHED(ramp), .THERM_ABSENT(absent), .EXT_COLD(cold),
        .EXT_HOT(hot), .PROT_EVENTS(prot), .STRING_OPEN(sopen), .STRING_SHORT(sshort),
        .STRING_SEL(ssel), .DIE_HEAT(heat), .SINK_LEVEL(sink), .DUTY(duty));
    sfrbk_host_model i_sfrbk_host_model (.clk(clk), .rdata(rdata), .rd_stb(rd_stb), .wr_stb(wr_stb),
        .addr(addr), .wdata(wdata));

    always #10 clk = ~clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] got;
        i_sfrbk_host_model.rd(a, got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED reg %h expected %h seen %h", a, exp, got);
        end
    endtask

    // async flags need five edges to land; six gives margin
    task automatic settle();
        repeat (6) @(negedge clk);
    endtask

    task automatic clr();
        i_sfrbk_host_model.wr(sfrbk_pkg::ADDR_CLEAR, 8'h01);
        settle();
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end

    initial
    begin
        clk = 1'b0; resetn = 1'b0; {ramp, absent, cold, hot, sopen, sshort} = 6'h00;
        prot = 7'h00; ssel = 4'h0; heat = 11'h000; sink = 12'h000; duty = 16'h0000;
        err_total = 0; n_checks = 0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        rchk(sfrbk_pkg::ADDR_CONDITION, sfrbk_pkg::RESET_BYTE);
        rchk(sfrbk_pkg::ADDR_PROTECTION, sfrbk_pkg::RESET_BYTE);
        rchk(sfrbk_pkg::ADDR_STRING, sfrbk_pkg::RESET_BYTE);
        rchk(sfrbk_pkg::ADDR_CLEAR, sfrbk_pkg::RESET_BYTE);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            {ramp, absent, cold, hot} = 4'h1 << i;
            settle();
            rchk(sfrbk_pkg::ADDR_CONDITION, {4'h0, 4'h1 << i});
        end
        {ramp, absent, cold, hot} = 4'h0;
        $display("test condition done");
        for (int i = 0; i < 7; i++)
        begin
            prot = 7'h01 << i;
            settle();
            prot = 7'h00;
            settle();
            rchk(sfrbk_pkg::ADDR_PROTECTION, {1'b0, 7'h01 << i});
            i_sfrbk_host_model.wr(sfrbk_pkg::ADDR_PROTECTION, 8'hff);
            rchk(sfrbk_pkg::ADDR_PROTECTION, {1'b0, 7'h01 << i});
            clr();
            rchk(sfrbk_pkg::ADDR_PROTECTION, 8'h00);
        end
        $display("test protection done");
        ssel = 4'h8; sopen = 1'b1; settle(); sopen = 1'b0; settle();
        rchk(sfrbk_pkg::ADDR_STRING, 8'h28);
        clr();
        ssel = 4'h1; sshort = 1'b1; settle(); sshort = 1'b0; settle();
        rchk(sfrbk_pkg::ADDR_STRING, 8'h11);
        clr();
        rchk(sfrbk_pkg::ADDR_STRING, 8'h00);
        $display("test strings done");
        rchk(sfrbk_pkg::ADDR_REVISION, {sfrbk_pkg::FULL_LAYER_REV, sfrbk_pkg::INTERCONNECT_MASK_REV});
        heat = 11'h5a3;
        rchk(sfrbk_pkg::ADDR_HEAT_HIGH, 8'h05);
        heat = 11'h2ff;
        rchk(sfrbk_pkg::ADDR_HEAT_LOW, 8'ha3);
        sink = 12'hc3d; duty = 16'hbeef;
        rchk(sfrbk_pkg::ADDR_SINK_HIGH, 8'h0c);
        sink = 12'h000; duty = 16'h1234;
        rchk(sfrbk_pkg::ADDR_SINK_LOW, 8'h3d);
        rchk(sfrbk_pkg::ADDR_DUTY_HIGH, 8'hbe);
        rchk(sfrbk_pkg::ADDR_DUTY_LOW, 8'hef);
        rchk(8'h20, 8'h00);
        $display("test readback done");
        close_out();
    end
endmodule // status_fault_readback_bank_tb_top
